// >>> rtl/usp_status_shadow.sv
/*
 Top of the UART status shadow and interrupt gate: four local registers
 at 10h..1Ch, good-data flags and the gated shareable PCI interrupt.
 Assumes UART cores, pin inversion, mode and power select come from
 same-clock logic; only the multi-purpose pins are asynchronous.
*/
`timescale 1ns/1ns
module usp_status_shadow import usp_pkg::*; (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic regRd,
  input wire logic regWr,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWdata,
  output logic [31:0] regRdata_r,
  output logic regAck_r,
  input wire usp_chan_t chanStat [USP_NCH],
  input wire logic [MIO_W-1:0] mioPin,
  input wire logic [MIO_W-1:0] mioInvert,
  input wire logic deviceMode,
  input wire logic [1:0] pmSelect,
  input wire logic ppIrq,
  input wire logic pdReq,
  output logic pciIntN_r,
  output logic pciIntOe_r
);
  logic [MIO_W-1:0] mioSync;
  logic [MIO_W-1:0] mioInt;
  logic [USP_NCH-1:0] goodNow;
  logic [2*LVL_W-1:0] rxl_r, rxl_nxt, txl_r, txl_nxt;
  logic [CODE_W-1:0] code_r [USP_NCH];
  logic [CODE_W-1:0] code_nxt [USP_NCH];
  logic [USP_NCH-1:0] errFifo_r, errFifo_nxt, ovr_r, ovr_nxt, good_r, good_nxt;
  logic [14:0] gisSrc_r, gisSrc_nxt;
  logic pdSticky_r, pdSticky_nxt;
  usp_mask_t mask_r, mask_nxt;
  logic [31:0] rdata_nxt;
  logic ack_nxt, intN_nxt, intOe_nxt, anyIrq;
  logic rdRxl, rdTxl, rdUis, rdGis, wrGis;

  // ==================================================
  // Pin synchroniser and inversion
  usp_sync u_sync (
    .ref_clk(ref_clk),
    .rst(rst),
    .pinIn(mioPin),
    .pinSync(mioSync)
  );
  assign mioInt = mioSync ^ mioInvert;

  // Good-data decision per channel
  for (genvar g = 0; g < USP_NCH; g++) begin : g_good
    usp_good_data u_good (
      .irqCode(code_r[g]),
      .errInFifo(errFifo_r[g]),
      .overrun(ovr_r[g]),
      .goodNow(goodNow[g])
    );
  end

  // ==================================================
  // Address decode
  // consecutive word decode
  assign rdRxl = regRd && (regAddr == OFS_RXL);
  assign rdTxl = regRd && (regAddr == OFS_TXL);
  assign rdUis = regRd && (regAddr == OFS_UIS);
  assign rdGis = regRd && (regAddr == OFS_GIS);
  assign wrGis = regWr && (regAddr == OFS_GIS);

  // ==================================================
  // Shadow next values
  always_comb begin
    rxl_nxt = {chanStat[1].rxFill, chanStat[0].rxFill};
    txl_nxt = {chanStat[1].txFill, chanStat[0].txFill};
    for (int i = 0; i < USP_NCH; i++) begin
      code_nxt[i] = chanStat[i].irqCode;
      ovr_nxt[i] = chanStat[i].overrun;
      // line read clears error, set wins
      errFifo_nxt[i] = chanStat[i].rxErrSet || (errFifo_r[i] && !chanStat[i].lsrRead);
      good_nxt[i] = goodNow[i];
    end
    gisSrc_nxt = '0;
    gisSrc_nxt[1:0] = {chanStat[1].irqReq, chanStat[0].irqReq};
    gisSrc_nxt[GIS_MIO0] = deviceMode ? ppIrq : mioInt[0];
    // pin 1 in every power mode; read and gate use the power-down flag when select is not 00
    gisSrc_nxt[GIS_MIO1] = mioInt[1];
    gisSrc_nxt[GIS_MIOHI_LSB +: MIOHI_W] = mioInt[MIO_W-1:2];
  end

  // Shadow registers
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rxl_r <= '0;
      txl_r <= '0;
      errFifo_r <= '0;
      ovr_r <= '0;
      good_r <= '1;
      gisSrc_r <= '0;
      for (int i = 0; i < USP_NCH; i++) begin
        code_r[i] <= CODE_NONE;
      end
    end else begin
      rxl_r <= rxl_nxt;
      txl_r <= txl_nxt;
      errFifo_r <= errFifo_nxt;
      ovr_r <= ovr_nxt;
      good_r <= good_nxt;
      gisSrc_r <= gisSrc_nxt;
      code_r <= code_nxt;
    end
  end

  // ==================================================
  // Mask and sticky power-down next values
  always_comb begin
    mask_nxt = mask_r;
    if (wrGis) begin
      mask_nxt.uartMask = regWdata[GIS_UMASK_LSB +: 2];
      mask_nxt.mio0Mask = regWdata[GIS_M0];
      mask_nxt.mio1Mask = regWdata[GIS_M1];
      mask_nxt.mioHiMask = regWdata[GIS_MIOMASK_LSB +: MIOHI_W];
    end
    pdSticky_nxt = (pmSelect != PM_MIO) && (pdReq || (pdSticky_r && !rdGis));
  end

  // Mask registers
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mask_r.uartMask <= UMASK_RST;
      mask_r.mio0Mask <= M0_RST;
      mask_r.mio1Mask <= (pmSelect == PM_MIO);
      mask_r.mioHiMask <= MIOMASK_RST;
      pdSticky_r <= 1'b0;
    end else begin
      mask_r <= mask_nxt;
      pdSticky_r <= pdSticky_nxt;
    end
  end

  // ==================================================
  // Read data next value
  always_comb begin
    rdata_nxt = '0;
    ack_nxt = regRd || regWr;
    if (rdRxl) begin
      rdata_nxt[2*LVL_W-1:0] = rxl_r;
    end
    if (rdTxl) begin
      rdata_nxt[2*LVL_W-1:0] = txl_r;
    end
    if (rdUis) begin
      rdata_nxt[CODE_W-1:0] = code_r[0];
      rdata_nxt[CODE_W +: CODE_W] = code_r[1];
      rdata_nxt[UIS_GOOD0] = good_r[0];
      rdata_nxt[UIS_GOOD1] = good_r[1];
      rdata_nxt[UIS_RSV_LSB +: 2] = UIS_RSV_VAL;
      rdata_nxt[UIS_GLOBAL] = good_r[0] && good_r[1];
    end
    if (rdGis) begin
      rdata_nxt[14:0] = gisSrc_r;
      if (pmSelect != PM_MIO) begin
        rdata_nxt[GIS_MIO1] = pdSticky_r;
      end
      rdata_nxt[GIS_UMASK_LSB +: 2] = mask_r.uartMask;
      rdata_nxt[GIS_M0] = mask_r.mio0Mask;
      rdata_nxt[GIS_M1] = mask_r.mio1Mask;
      rdata_nxt[GIS_MIOMASK_LSB +: MIOHI_W] = mask_r.mioHiMask;
    end
  end

  // Read port registers
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      regRdata_r <= '0;
      regAck_r <= 1'b0;
    end else begin
      regRdata_r <= rdata_nxt;
      regAck_r <= ack_nxt;
    end
  end

  // ==================================================
  // Interrupt gate
  always_comb begin
    // core request and mask both needed
    anyIrq = |(gisSrc_r[1:0] & mask_r.uartMask);
    anyIrq = anyIrq || (gisSrc_r[GIS_MIO0] && mask_r.mio0Mask);
    if (pmSelect == PM_MIO) begin
      anyIrq = anyIrq || (gisSrc_r[GIS_MIO1] && mask_r.mio1Mask);
    end else begin
      anyIrq = anyIrq || (pdSticky_r && mask_r.mio1Mask);
    end
    anyIrq = anyIrq || (|(gisSrc_r[GIS_MIOHI_LSB +: MIOHI_W] & mask_r.mioHiMask));
    // drive low while any unmasked source active
    intN_nxt = !anyIrq;
    intOe_nxt = anyIrq;
  end

  // Interrupt pin registers
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pciIntN_r <= 1'b1;
      pciIntOe_r <= 1'b0;
    end else begin
      pciIntN_r <= intN_nxt;
      pciIntOe_r <= intOe_nxt;
    end
  end

  // ==================================================
  // Assertions
  property p_rx_level;
    @(posedge ref_clk) disable iff (rst) rdRxl |=> regRdata_r == {16'h0000, $past(rxl_r)};
  endproperty
  a_rx_level: assert property (p_rx_level) else $error("rx level read wrong");

  property p_tx_level;
    @(posedge ref_clk) disable iff (rst) rdTxl |=> regRdata_r[31:16] == 16'h0000 && regRdata_r[15:0] == $past(txl_r);
  endproperty
  a_tx_level: assert property (p_tx_level) else $error("tx level read wrong");

  property p_code_reset;
    @(posedge ref_clk) $past(rst) && !rst |-> code_r[0] == CODE_NONE && code_r[1] == CODE_NONE;
  endproperty
  a_code_reset: assert property (p_code_reset) else $error("source code reset wrong");

  property p_global_good;
    @(posedge ref_clk) disable iff (rst)
      rdUis |=> regRdata_r[UIS_GLOBAL] == (regRdata_r[UIS_GOOD0] && regRdata_r[UIS_GOOD1]);
  endproperty
  a_global_good: assert property (p_global_good) else $error("global good not AND");

  property p_bad_code;
    @(posedge ref_clk) disable iff (rst) (!usp_code_ok(code_r[0]) || errFifo_r[0] || ovr_r[0]) |=> !good_r[0];
  endproperty
  a_bad_code: assert property (p_bad_code) else $error("good set on bad state");

  property p_err_clear;
    @(posedge ref_clk) disable iff (rst) chanStat[0].lsrRead && !chanStat[0].rxErrSet |=> !errFifo_r[0];
  endproperty
  a_err_clear: assert property (p_err_clear) else $error("error flag not cleared");

  property p_pd_sticky;
    @(posedge ref_clk) disable iff (rst) pdReq && pmSelect != PM_MIO ##1 pmSelect != PM_MIO && !rdGis |=> pdSticky_r;
  endproperty
  a_pd_sticky: assert property (p_pd_sticky) else $error("power-down flag lost");

  property p_mask_reset;
    @(posedge ref_clk) $past(rst) && !rst |-> mask_r.uartMask == UMASK_RST && mask_r.mio0Mask == M0_RST;
  endproperty
  a_mask_reset: assert property (p_mask_reset) else $error("mask reset wrong");

  property p_irq_held;
    @(posedge ref_clk) disable iff (rst) anyIrq [*2] |=> !pciIntN_r && pciIntOe_r;
  endproperty
  a_irq_held: assert property (p_irq_held) else $error("interrupt not driven");

  property p_irq_idle;
    @(posedge ref_clk) disable iff (rst) mask_r == '0 |=> pciIntN_r && !pciIntOe_r;
  endproperty
  a_irq_idle: assert property (p_irq_idle) else $error("masked source drove interrupt");

  c_burst: cover property (@(posedge ref_clk) disable iff (rst) rdRxl ##1 rdTxl ##1 rdUis ##1 rdGis);
  c_irq: cover property (@(posedge ref_clk) disable iff (rst) $fell(pciIntN_r));
  c_pd_clear: cover property (@(posedge ref_clk) disable iff (rst) pdSticky_r && rdGis ##1 !pdSticky_r);
  c_bad: cover property (@(posedge ref_clk) disable iff (rst) $fell(good_r[1]));
endmodule

// >>> rtl/usp_pkg.sv
/*
 Constants, field layouts and carrier types of the UART status shadow block.
 Assumes the UART codes follow the common 550-style source encoding.
*/
package usp_pkg;
  // ==================================================
  // Sizes
  localparam int USP_NCH = 2;
  localparam int MIO_W = 11;

  // ==================================================
  // Register offsets
  localparam logic [7:0] OFS_RXL = 8'h10;
  localparam logic [7:0] OFS_TXL = 8'h14;
  localparam logic [7:0] OFS_UIS = 8'h18;
  localparam logic [7:0] OFS_GIS = 8'h1C;

  // ==================================================
  // Field positions
  localparam int LVL_W = 8;
  localparam int CODE_W = 6;
  localparam int UIS_GOOD0 = 27;
  localparam int UIS_GOOD1 = 28;
  localparam int UIS_RSV_LSB = 29;
  localparam int UIS_GLOBAL = 31;
  localparam int GIS_MIO0 = 4;
  localparam int GIS_MIO1 = 5;
  localparam int GIS_MIOHI_LSB = 6;
  localparam int GIS_UMASK_LSB = 16;
  localparam int GIS_M0 = 20;
  localparam int GIS_M1 = 21;
  localparam int GIS_MIOMASK_LSB = 22;
  localparam int MIOHI_W = 9;

  // ==================================================
  // Reset values and fixed read values
  localparam logic [CODE_W-1:0] CODE_NONE = 6'h01;
  localparam logic [CODE_W-1:0] CODE_THRE = 6'h02;
  localparam logic [CODE_W-1:0] CODE_RDA = 6'h04;
  localparam logic [CODE_W-1:0] CODE_RTO = 6'h0C;
  localparam logic [1:0] UMASK_RST = 2'h3;
  localparam logic M0_RST = 1'h1;
  localparam logic [MIOHI_W-1:0] MIOMASK_RST = 9'h1FF;
  localparam logic [1:0] UIS_RSV_VAL = 2'h3;
  localparam logic [1:0] PM_MIO = 2'h0;

  // ==================================================
  // Per-channel status from a UART core
  typedef struct packed {
    logic [LVL_W-1:0] rxFill;
    logic [LVL_W-1:0] txFill;
    logic [CODE_W-1:0] irqCode;
    logic irqReq;
    logic rxErrSet;
    logic lsrRead;
    logic overrun;
  } usp_chan_t;

  // Software mask bits of the global register
  typedef struct packed {
    logic [1:0] uartMask;
    logic mio0Mask;
    logic mio1Mask;
    logic [MIOHI_W-1:0] mioHiMask;
  } usp_mask_t;

  // Source codes that still allow good data
  function automatic logic usp_code_ok(input logic [CODE_W-1:0] c);
    return (c == CODE_NONE) || (c == CODE_RDA) || (c == CODE_RTO) || (c == CODE_THRE);
  endfunction
endpackage

// >>> rtl/usp_sync.sv
/*
 Two-stage synchroniser for the multi-purpose pins.
 Assumes the pins are asynchronous to ref_clk.
*/
`timescale 1ns/1ns
module usp_sync import usp_pkg::*; (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [MIO_W-1:0] pinIn,
  output logic [MIO_W-1:0] pinSync
);
  logic [MIO_W-1:0] stage1_r;
  logic [MIO_W-1:0] stage2_r;
  logic [MIO_W-1:0] stage1_nxt;
  logic [MIO_W-1:0] stage2_nxt;

  // ==================================================
  // Next stage values
  always_comb begin
    stage1_nxt = pinIn;
    stage2_nxt = stage1_r;
  end

  // Register both stages
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      stage1_r <= '0;
      stage2_r <= '0;
    end else begin
      stage1_r <= stage1_nxt;
      stage2_r <= stage2_nxt;
    end
  end

  assign pinSync = stage2_r;
endmodule

// >>> rtl/usp_good_data.sv
/*
 Good-data decision for one UART channel.
 Assumes registered shadow inputs on the same clock.
*/
`timescale 1ns/1ns
module usp_good_data import usp_pkg::*; (
  input wire logic [CODE_W-1:0] irqCode,
  input wire logic errInFifo,
  input wire logic overrun,
  output logic goodNow
);
  // ==================================================
  // three-way good test
  assign goodNow = usp_code_ok(irqCode) && !errInFifo && !overrun;
endmodule

// >>> test/usp_host_model.sv
/*
 Host driver model: back-to-back register accesses on the strobe port.
 Assumes one-cycle strobes, answer one cycle after each strobe.
*/
`timescale 1ns/1ns
module usp_host_model (
  input wire logic ref_clk,
  output logic regRd,
  output logic regWr,
  output logic [7:0] regAddr,
  output logic [31:0] regWdata,
  input wire logic [31:0] regRdata_r,
  input wire logic regAck_r
);
  int nMiss;

  // ==================================================
  // Idle bus at time zero
  initial begin
    regRd = 1'b0;
    regWr = 1'b0;
    regAddr = 8'h00;
    regWdata = 32'h0;
    nMiss = 0;
  end

  // ==================================================
  // Burst of accesses, one word per strobe, answers collected in order
  // levels listed before source
  task automatic access(input bit wr, input logic [7:0] a[$], input logic [31:0] wd, output logic [31:0] rd[$]);
    rd = {};
    for (int k = 0; k <= a.size(); k++) begin
      @(negedge ref_clk);
      if (k > 0) begin
        if (regAck_r !== 1'b1) nMiss++;
        rd.push_back(regRdata_r);
      end
      regRd <= !wr && (k < a.size());
      regWr <= wr && (k < a.size());
      regAddr <= (k < a.size()) ? a[k] : 8'h00;
      regWdata <= wd;
    end
  endtask
endmodule

// >>> test/usp_status_shadow_tb.sv
/*
 Self-checking bench of the status shadow block with a behavioural model.
 Assumes the host model file and the design package are compiled first.
*/
`timescale 1ns/1ns
module usp_status_shadow_tb import usp_pkg::*;;
  localparam logic [31:0] WMASK = 32'h7FF30000;
  logic ref_clk = 1'b0;
  logic rst, regRd, regWr, regAck_r, pciIntN_r, pciIntOe_r;
  logic deviceMode, ppIrq, pdReq, sticky;
  logic [1:0] pmSelect;
  logic [1:0] errQ;
  logic [7:0] regAddr;
  logic [31:0] regWdata, regRdata_r, mk, seed, w;
  logic [MIO_W-1:0] mioPin, mioInvert;
  logic [7:0] burstQ[$], oneQ[$];
  logic [31:0] d[$];
  logic [5:0] codes[8] = '{6'h01, 6'h02, 6'h04, 6'h0C, 6'h06, 6'h00, 6'h10, 6'h20};
  usp_chan_t cs [USP_NCH];
  int n_fail = 0;
  int comparisons = 0;

  usp_status_shadow u_usp_status_shadow (.ref_clk(ref_clk), .rst(rst), .regRd(regRd), .regWr(regWr),
    .regAddr(regAddr), .regWdata(regWdata), .regRdata_r(regRdata_r), .regAck_r(regAck_r), .chanStat(cs),
    .mioPin(mioPin), .mioInvert(mioInvert), .deviceMode(deviceMode), .pmSelect(pmSelect), .ppIrq(ppIrq),
    .pdReq(pdReq), .pciIntN_r(pciIntN_r), .pciIntOe_r(pciIntOe_r));
  usp_host_model u_usp_host_model (.ref_clk(ref_clk), .regRd(regRd), .regWr(regWr), .regAddr(regAddr),
    .regWdata(regWdata), .regRdata_r(regRdata_r), .regAck_r(regAck_r));

  // ==================================================
  // Clock and helpers
  always #20 ref_clk = ~ref_clk;

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic bit codeOk(input logic [5:0] c);
    return c == 6'h01 || c == 6'h04 || c == 6'h0C || c == 6'h02;
  endfunction

  // Expected source shadow word
  function automatic logic [31:0] uisExp();
    logic [1:0] gd;
    for (int i = 0; i < 2; i++) gd[i] = codeOk(cs[i].irqCode) && !errQ[i] && !cs[i].overrun;
    return {gd[0] & gd[1], 2'h3, gd[1], gd[0], 15'h0, cs[1].irqCode, cs[0].irqCode};
  endfunction

  // Expected global status word
  function automatic logic [31:0] gisExp();
    logic [10:0] p;
    logic [31:0] g;
    p = mioPin ^ mioInvert;
    g = mk;
    g[1:0] = {cs[1].irqReq, cs[0].irqReq};
    g[4] = deviceMode ? ppIrq : p[0];
    g[5] = (pmSelect == 2'h0) ? p[1] : sticky;
    g[14:6] = p[10:2];
    return g;
  endfunction

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wrap_up();
    n_fail += u_usp_host_model.nMiss;
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Model state after a reset
  task automatic mreset();
    mk = WMASK & ~(32'h1 << GIS_M1);
    mk[GIS_M1] = (pmSelect == 2'h0);
    sticky = 1'b0;
    errQ = 2'h0;
  endtask

  // Interrupt pin, then one burst over all four words
  task automatic check_all(input string nm);
    logic [31:0] g;
    logic any;
    repeat (6) @(negedge ref_clk);
    g = gisExp();
    any = |({g[14:6], g[5], g[4], g[1:0]} & {mk[30:22], mk[21], mk[20], mk[17:16]});
    chk("pciIntN", {31'h0, !any}, {31'h0, pciIntN_r});
    chk("pciIntOe", {31'h0, any}, {31'h0, pciIntOe_r});
    u_usp_host_model.access(1'b0, burstQ, 32'h0, d);
    chk("rxLevels", {16'h0, cs[1].rxFill, cs[0].rxFill}, d[0]);
    chk("txLevels", {16'h0, cs[1].txFill, cs[0].txFill}, d[1]);
    chk("irqSource", uisExp(), d[2]);
    chk("globalStatus", g, d[3]);
    // Driver decodes the code field of a channel without good data
    if (!d[2][UIS_GOOD1]) chk("ch1Code", {26'h0, cs[1].irqCode}, {26'h0, d[2][11:6]});
    if (!d[2][UIS_GOOD0]) chk("ch0Code", {26'h0, cs[0].irqCode}, {26'h0, d[2][5:0]});
    sticky = 1'b0;
    $display("test %s done", nm);
  endtask

  task automatic pulse(input int ch, input bit line_state_register);
    @(negedge ref_clk);
    cs[ch].rxErrSet = !line_state_register;
    cs[ch].lsrRead = line_state_register;
    @(negedge ref_clk);
    cs[ch].rxErrSet = 1'b0;
    cs[ch].lsrRead = 1'b0;
    errQ[ch] = !line_state_register;
  endtask

  // ==================================================
  // Watchdog
  initial begin
    repeat (20000) @(posedge ref_clk);
    n_fail++;
    wrap_up();
  end

  // ==================================================
  // Main sequence
  initial begin
    seed = 32'h1DCA;
    rst = 1'b1;
    for (int i = 0; i < 2; i++) cs[i] = '{irqCode: CODE_NONE, default: '0};
    {mioPin, mioInvert, deviceMode, pmSelect, ppIrq, pdReq} = '0;
    burstQ = {OFS_RXL, OFS_TXL, OFS_UIS, OFS_GIS};
    repeat (2) @(negedge ref_clk);
    rst = 1'b0;
    mreset();
    check_all("reset");
    oneQ = {8'h20};
    u_usp_host_model.access(1'b0, oneQ, 32'h0, d);
    chk("unmapped", 32'h0, d[0]);
    for (int n = 0; n < 10; n++) begin
      @(negedge ref_clk);
      for (int i = 0; i < 2; i++) begin
        w = rnd();
        cs[i].rxFill = w[7:0];
        cs[i].txFill = w[15:8];
        cs[i].irqCode = codes[w[18:16]];
        cs[i].overrun = w[19] & w[20];
        cs[i].irqReq = w[21];
      end
      w = rnd();
      {mioPin, mioInvert, deviceMode, ppIrq} = w[23:0];
      oneQ = {OFS_RXL};
      u_usp_host_model.access(1'b1, oneQ, rnd(), d);
      oneQ = {OFS_GIS};
      w = rnd();
      // Last pass clears every mask while sources stay live
      if (n == 9) w = 32'h0;
      u_usp_host_model.access(1'b1, oneQ, w, d);
      mk = w & WMASK;
      check_all("random");
    end
    @(negedge ref_clk);
    for (int i = 0; i < 2; i++) cs[i] = '{irqCode: CODE_RDA, rxFill: 8'h05, default: '0};
    {mioPin, mioInvert, deviceMode} = '0;
    pulse(1, 1'b0);
    check_all("fifo error");
    pulse(1, 1'b1);
    check_all("line status read");
    @(negedge ref_clk);
    pmSelect = 2'h1;
    oneQ = {OFS_GIS};
    u_usp_host_model.access(1'b1, oneQ, 32'h00200000, d);
    mk = 32'h00200000;
    check_all("power mode idle");
    @(negedge ref_clk);
    pdReq = 1'b1;
    @(negedge ref_clk);
    pdReq = 1'b0;
    sticky = 1'b1;
    check_all("power down set");
    check_all("power down cleared");
    @(negedge ref_clk);
    rst = 1'b1;
    repeat (2) @(negedge ref_clk);
    rst = 1'b0;
    mreset();
    check_all("second reset");
    wrap_up();
  end
endmodule
